// ===== design/esx_engine_ctrl.sv
// engine stop solenoid, alternator excitation, failure check, speed source
// assumes inputs synchronous to sys_clk; slave AHB-Lite, single word transfers
`include "esx_consts.svh"
`default_nettype none
module esx_engine_ctrl
    import esx_pkg::*;
#(
    parameter int EXC_HOLD_MS   = `ESX_EXC_HOLD_MS,
    parameter int EXC_TOGGLE_MS = `ESX_EXC_TOGGLE_MS,
    parameter int EXC_AFTER_MS  = `ESX_EXC_AFTER_MS,
    parameter int GATE_MS       = `ESX_GATE_MS,
    parameter int TICK_CYC      = `ESX_TICK_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        startReq,
    input  wire logic        stopReq,
    input  wire logic        engineStopped,
    input  wire logic        supply24v,
    input  wire logic [11:0] excVolt,
    input  wire logic        pickupIn,
    input  wire logic        altFreqIn,
    input  wire logic [15:0] ecuRpm,
    output logic [5:0]       staticOut,
    output logic             startCmd,
    output logic             excCmd,
    output logic             excHighCurrent,
    output logic             altFailAnomaly,
    output logic             engineStopFault,
    output logic [15:0]      engineRpm,
    output logic [7:0]       speedPercent
);
    // ==========
    // register map
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STOPDUR = 8'h04;
    localparam logic [7:0] A_EXCTH   = 8'h08;
    localparam logic [7:0] A_FAIL    = 8'h0C;
    localparam logic [7:0] A_SPEED   = 8'h10;
    localparam logic [7:0] A_RATIO   = 8'h14;
    localparam logic [7:0] A_STATUS  = 8'h18;
    localparam logic [7:0] A_RPM     = 8'h1C;

    logic [7:0]  excFuncSel_reg;
    logic [2:0]  stopOutSel_reg;
    logic [2:0]  startOutSel_reg;
    esx_src_t    speedSrc_reg;
    logic [15:0] stopDurMs_reg;
    logic [11:0] runThLo_reg;
    logic [11:0] runThHi_reg;
    logic [15:0] failDelayMs_reg;
    esx_act_t    failAction_reg;
    logic [15:0] ratedRpm_reg;
    logic [7:0]  teeth_reg;
    logic [15:0] altRatio_reg;   // 8.8 fixed point

    logic        apValid_reg;
    logic        apWrite_reg;
    logic [7:0]  apAddr_reg;

    // ==========
    // time base
    logic [$clog2(TICK_CYC)-1:0] tickCnt_reg;
    logic                        tick;
    logic [15:0]                 gateCnt_reg;
    logic                        gate;
    assign tick = (tickCnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));
    assign gate = tick && (gateCnt_reg == 16'(GATE_MS - 1));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tickCnt_reg <= '0;
            gateCnt_reg <= 16'h0000;
        end else begin
            tickCnt_reg <= tick ? '0 : tickCnt_reg + 1'b1;
            if (gate)
                gateCnt_reg <= 16'h0000;
            else if (tick)
                gateCnt_reg <= gateCnt_reg + 16'h0001;
        end
    end

    // ==========
    // bus slave: zero wait states, always OKAY
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            apValid_reg <= 1'b0;
            apWrite_reg <= 1'b0;
            apAddr_reg  <= 8'h00;
        end else if (hready) begin
            apValid_reg <= hsel && htrans[1];
            apWrite_reg <= hwrite;
            apAddr_reg  <= haddr[7:0];
        end
    end

    logic wr;
    assign wr = apValid_reg && apWrite_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            excFuncSel_reg  <= 8'h00;
            stopOutSel_reg  <= 3'h2;
            startOutSel_reg <= 3'h0;
            speedSrc_reg    <= ESX_SRC_PICKUP;
            stopDurMs_reg   <= 16'h2710;
            runThLo_reg     <= 12'h000;
            runThHi_reg     <= 12'h000;
            failDelayMs_reg <= 16'h0000;
            failAction_reg  <= ESX_ACT_WARN;
            ratedRpm_reg    <= 16'h05DC;
            teeth_reg       <= 8'h00;
            altRatio_reg    <= 16'h0100;
        end else if (wr) begin
            case (apAddr_reg)
                A_CTRL: begin
                    excFuncSel_reg  <= hwdata[7:0];
                    stopOutSel_reg  <= hwdata[10:8];
                    startOutSel_reg <= hwdata[14:12];
                    speedSrc_reg    <= esx_src_t'(hwdata[17:16]);
                    failAction_reg  <= esx_act_t'(hwdata[21:20]);
                end
                A_STOPDUR: stopDurMs_reg <= hwdata[15:0];
                A_EXCTH: begin
                    runThLo_reg <= hwdata[11:0];
                    runThHi_reg <= hwdata[27:16];
                end
                A_FAIL:  failDelayMs_reg <= hwdata[15:0];
                A_SPEED: begin
                    ratedRpm_reg <= hwdata[15:0];
                    teeth_reg    <= hwdata[23:16];
                end
                A_RATIO: altRatio_reg <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ==========
    // stop solenoid
    logic        stopActive_reg;
    logic [15:0] stopMs_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stopActive_reg <= 1'b0;
            stopMs_reg     <= 16'h0000;
        end else if ((stopReq || engineStopFault) && !stopActive_reg && !engineStopped) begin
            stopActive_reg <= 1'b1;
            stopMs_reg     <= 16'h0000;
        end else if (stopActive_reg) begin
            if (engineStopped || stopMs_reg >= stopDurMs_reg)
                stopActive_reg <= 1'b0;
            else if (tick)
                stopMs_reg <= stopMs_reg + 16'h0001;
        end
    end

    // ==========
    // start command and running detection
    logic excFunc;
    logic runDetEn;
    logic running;
    logic [7:0] relMs_reg;
    logic       startCmdInt;

    assign excFunc  = (excFuncSel_reg == `ESX_EXC_FUNC_SEL);
    assign runDetEn = excFunc && runThLo_reg != 12'h000
                      && runThHi_reg > runThLo_reg;
    assign running  = (runDetEn && excVolt > runThHi_reg) || !engineStopped;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            startCmdInt <= 1'b0;
            relMs_reg   <= 8'h00;
        end else if (!startCmdInt) begin
            relMs_reg <= 8'h00;
            if (startReq && !stopReq && !stopActive_reg && !running)
                startCmdInt <= 1'b1;
        end else if (!startReq || stopReq || stopActive_reg) begin
            startCmdInt <= 1'b0;
        end else if (running) begin
            if (relMs_reg >= 8'(`ESX_START_REL_MS))
                startCmdInt <= 1'b0;
            else if (tick)
                relMs_reg <= relMs_reg + 8'h01;
        end
    end

    // ==========
    // excitation sequencing
    logic [15:0] excMs_reg;
    logic        excPhase_reg;
    logic [15:0] afterMs_reg;
    logic        excNext;
    logic        startCmdWas_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            excMs_reg    <= 16'h0000;
            excPhase_reg <= 1'b0;
            afterMs_reg  <= 16'h0000;
        end else if (startCmdInt) begin
            afterMs_reg <= 16'h0000;
            if (tick) begin
                if (excMs_reg >= 16'(EXC_HOLD_MS - 1)) begin
                    excMs_reg    <= 16'(EXC_HOLD_MS - EXC_TOGGLE_MS);
                    excPhase_reg <= ~excPhase_reg;
                end else begin
                    excMs_reg <= excMs_reg + 16'h0001;
                end
            end
        end else begin
            excMs_reg    <= 16'h0000;
            excPhase_reg <= 1'b0;
            if (tick && afterMs_reg < 16'(EXC_AFTER_MS))
                afterMs_reg <= afterMs_reg + 16'h0001;
        end
    end

    // then lingers after release
    assign excNext = excFunc && ((startCmdInt && !excPhase_reg)
                     || (!startCmdInt && startCmdWas_reg
                         && afterMs_reg < 16'(EXC_AFTER_MS)));
    always_ff @(posedge sys_clk) begin
        if (srst)
            startCmdWas_reg <= 1'b0;
        else if (startCmdInt && excFunc)
            startCmdWas_reg <= 1'b1;
        else if (afterMs_reg >= 16'(EXC_AFTER_MS))
            startCmdWas_reg <= 1'b0;
    end

    // ==========
    // alternator failure
    logic [15:0] failMs_reg;
    logic        failCond;
    assign failCond = excFunc && !engineStopped && !startCmdInt
                      && excVolt <= 12'(`ESX_ZERO_VOLT);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            failMs_reg     <= 16'h0000;
            altFailAnomaly <= 1'b0;
        end else if (!failCond || failDelayMs_reg == 16'h0000) begin
            failMs_reg <= 16'h0000;
            if (engineStopped || failDelayMs_reg == 16'h0000)
                altFailAnomaly <= 1'b0;
        end else if (failMs_reg >= failDelayMs_reg) begin
            altFailAnomaly <= 1'b1;
        end else if (tick) begin
            failMs_reg <= failMs_reg + 16'h0001;
        end
    end

    // ==========
    // speed measurement
    logic [15:0] pickCnt;
    logic [15:0] altCnt;
    logic [31:0] pickRpm;
    logic [31:0] altRpm;
    logic [15:0] rpmSel;
    logic [31:0] pct;

    esx_freq_meter #(.WIDTH(16)) uPick (
        .sys_clk (sys_clk),
        .srst    (srst),
        .sigIn   (pickupIn),
        .gate    (gate),
        .count   (pickCnt)
    );
    esx_freq_meter #(.WIDTH(16)) uAlt (
        .sys_clk (sys_clk),
        .srst    (srst),
        .sigIn   (altFreqIn),
        .gate    (gate),
        .count   (altCnt)
    );

    // one second gate: count equals hertz
    assign pickRpm = (teeth_reg == 8'h00) ? 32'h0 :
                     (32'(pickCnt) * 32'(`ESX_RPM_PER_HZ)) / 32'(teeth_reg);
    assign altRpm  = (32'(altCnt) * 32'(altRatio_reg)) >> 8;

    always_comb begin
        case (speedSrc_reg)
            ESX_SRC_PICKUP: rpmSel = pickRpm[15:0];
            ESX_SRC_ALT:    rpmSel = altRpm[15:0];
            ESX_SRC_BOTH:   rpmSel = (teeth_reg != 8'h00) ? pickRpm[15:0] : altRpm[15:0];
            ESX_SRC_ECU:    rpmSel = ecuRpm;
            default:        rpmSel = 16'h0000;
        endcase
    end
    assign pct = (ratedRpm_reg == 16'h0000) ? 32'h0 :
                 (32'(rpmSel) * 32'd100) / 32'(ratedRpm_reg);

    // ==========
    // outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            staticOut       <= 6'h00;
            startCmd        <= 1'b0;
            excCmd          <= 1'b0;
            excHighCurrent  <= 1'b0;
            engineStopFault <= 1'b0;
            engineRpm       <= 16'h0000;
            speedPercent    <= 8'h00;
        end else begin
            staticOut <= 6'h00;
            if (stopActive_reg && stopOutSel_reg < 3'(`ESX_OUT_COUNT))
                staticOut[stopOutSel_reg] <= 1'b1;
            if (startCmdInt && startOutSel_reg < 3'(`ESX_OUT_COUNT))
                staticOut[startOutSel_reg] <= 1'b1;
            startCmd        <= startCmdInt;
            excCmd          <= excNext;
            excHighCurrent  <= ~supply24v;
            engineStopFault <= altFailAnomaly && failAction_reg == ESX_ACT_STOP;
            engineRpm       <= rpmSel;
            speedPercent    <= (pct > 32'd255) ? 8'hFF : pct[7:0];
        end
    end

    // ==========
    // read data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= 32'h0000_0000;
            if (hready && hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    A_CTRL:    hrdata <= {10'h000, failAction_reg, 2'h0, speedSrc_reg, 1'b0,
                                          startOutSel_reg, 1'b0, stopOutSel_reg, excFuncSel_reg};
                    A_STOPDUR: hrdata <= {16'h0000, stopDurMs_reg};
                    A_EXCTH:   hrdata <= {4'h0, runThHi_reg, 4'h0, runThLo_reg};
                    A_FAIL:    hrdata <= {16'h0000, failDelayMs_reg};
                    A_SPEED:   hrdata <= {8'h00, teeth_reg, ratedRpm_reg};
                    A_RATIO:   hrdata <= {16'h0000, altRatio_reg};
                    A_STATUS:  hrdata <= {26'h0, engineStopFault, altFailAnomaly, excCmd,
                                          startCmd, stopActive_reg, runDetEn};
                    A_RPM:     hrdata <= {8'h00, speedPercent, engineRpm};
                    default:   ;
                endcase
            end
        end
    end
endmodule // esx_engine_ctrl
`default_nettype wire

// ===== design/esx_consts.svh
// constants for the engine stop / excitation / speed control block
// assumes a 10 MHz sys_clk and a 1 ms tick derived inside the block
//
// Operation
// - assert stop solenoid when stopping engine
// - release stop at standstill or pulse timeout
// - stop function routable to any static output
// - excitation input only when function selected
// - excitation on together with start command
// - excitation 30 s, then toggle every 5 s
// - excitation held 5 s after start release
// - excitation current level from supply class
// - running detect needs both thresholds, second higher
// - excitation near zero while running is failure
// - failure lasting delay raises alternator anomaly
// - action parameter selects fault class, stop; only the stop class has an effect here (engineStopFault)
// - zero failure delay never raises anomaly
// - speed from pick-up, alternator, both, or ECU
// - speed thresholds are percent of rated speed
// - pick-up speed from frequency and tooth count
// - zero tooth count disables pick-up speed
// - start released 200 to 300 ms after running
// - alternator speed uses fractional ratio
`ifndef ESX_CONSTS_SVH
`define ESX_CONSTS_SVH

`define ESX_CLK_HZ          10000000
`define ESX_TICK_MS         1
`define ESX_TICK_CYC        (`ESX_CLK_HZ / 1000 * `ESX_TICK_MS)
`define ESX_EXC_HOLD_MS     30000
`define ESX_EXC_TOGGLE_MS   5000
`define ESX_EXC_AFTER_MS    5000
`define ESX_START_REL_MS    200
`define ESX_GATE_MS         1000
`define ESX_RPM_PER_HZ      60
`define ESX_EXC_FUNC_SEL    8'h01
`define ESX_OUT_COUNT       6
`define ESX_ZERO_VOLT       12'h010

`endif

// ===== design/esx_pkg.sv
// types shared by the engine control block
// no assumptions beyond a SystemVerilog compiler
`default_nettype none
package esx_pkg;
    typedef enum logic [1:0] {ESX_SRC_PICKUP, ESX_SRC_ALT, ESX_SRC_BOTH, ESX_SRC_ECU} esx_src_t;
    typedef enum logic [1:0] {ESX_ACT_NONE, ESX_ACT_WARN, ESX_ACT_SLOW, ESX_ACT_STOP} esx_act_t;
endpackage
`default_nettype wire

// ===== design/esx_freq_meter.sv
// pulse counter over a fixed gate; reports edges per gate window
// assumes input synchronous to sys_clk, one gate pulse per window
`default_nettype none
module esx_freq_meter #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             sigIn,
    input  wire logic             gate,
    output logic [WIDTH-1:0]      count
);
    logic             sigDly_reg;
    logic [WIDTH-1:0] acc_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sigDly_reg <= 1'b0;
            acc_reg    <= '0;
            count      <= '0;
        end else begin
            sigDly_reg <= sigIn;
            if (gate) begin
                count   <= acc_reg;
                acc_reg <= '0;
            end else if (sigIn && !sigDly_reg && acc_reg != '1) begin
                acc_reg <= acc_reg + 1'b1;
            end
        end
    end
endmodule // esx_freq_meter
`default_nettype wire

// ===== verification/esx_engine_ctrl_chk.sv
// checker for the engine control block
// assumes start on static output 0, stop on any of outputs 1..5
`default_nettype none
module esx_engine_ctrl_chk #(
    parameter int EXC_AFTER_MS = 5,
    parameter int TICK_CYC     = 10
) (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        hreadyout,
    input wire logic        startReq,
    input wire logic        stopReq,
    input wire logic        engineStopped,
    input wire logic        supply24v,
    input wire logic [11:0] excVolt,
    input wire logic [5:0]  staticOut,
    input wire logic        startCmd,
    input wire logic        excCmd,
    input wire logic        excHighCurrent,
    input wire logic        altFailAnomaly,
    input wire logic        engineStopFault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ==========
    // counters: crank while running, exc after release
    int runCnt;
    int afterCnt;
    always_ff @(posedge sys_clk) begin
        if (srst || !startCmd || engineStopped)
            runCnt <= 0;
        else
            runCnt <= runCnt + 1;
    end
    always_ff @(posedge sys_clk) begin
        if (srst || startCmd || !excCmd)
            afterCnt <= 0;
        else
            afterCnt <= afterCnt + 1;
    end
    // ==========
    // properties
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_exc_with_start: assert property ($rose(excCmd) |-> startCmd || $past(startCmd))
        else $error("exc without start");
    a_current_class: assert property (!$past(srst) |-> excHighCurrent == !$past(supply24v))
        else $error("current class");
    a_fault_needs_anom: assert property (engineStopFault |-> altFailAnomaly || $past(altFailAnomaly))
        else $error("stray stop fault");
    a_start_drops: assert property ($fell(startReq) |-> ##[0:2] !startCmd) else $error("start held");
    a_stop_blocks_start: assert property (stopReq |-> ##[0:2] !startCmd)
        else $error("start during stop");
    a_run_release_max: assert property (runCnt <= 300 * TICK_CYC)
        else $error("start held long");
    a_run_release_min: assert property ($fell(startCmd) && $past(startReq) && !$past(stopReq) && !engineStopped
        |-> $past(runCnt) >= 190 * TICK_CYC) else $error("start released too early");
    a_exc_after_max: assert property (afterCnt <= (EXC_AFTER_MS + 1) * TICK_CYC)
        else $error("exc held long");
    a_exc_after_min: assert property ($fell(excCmd) && !startCmd && !$past(startCmd)
        |-> $past(afterCnt) >= (EXC_AFTER_MS - 1) * TICK_CYC) else $error("excitation short");
    a_stop_idle: assert property (engineStopped [*4] |-> staticOut[5:1] == 5'h00)
        else $error("stop at standstill");
    a_fail_low_volt: assert property ($rose(altFailAnomaly) |-> $past(excVolt, 3) <= 12'h010)
        else $error("anomaly with volts");
endmodule // esx_engine_ctrl_chk

bind esx_engine_ctrl esx_engine_ctrl_chk #(.EXC_AFTER_MS(EXC_AFTER_MS), .TICK_CYC(TICK_CYC)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .hreadyout(hreadyout), .startReq(startReq), .stopReq(stopReq),
    .engineStopped(engineStopped), .supply24v(supply24v), .excVolt(excVolt), .staticOut(staticOut),
    .startCmd(startCmd), .excCmd(excCmd), .excHighCurrent(excHighCurrent),
    .altFailAnomaly(altFailAnomaly), .engineStopFault(engineStopFault)
);
`default_nettype wire

// ===== verification/esx_engine_model.sv
// behavioural engine: starter, stop solenoid, charge alternator, pick-up
// assumes control inputs change right after rising edges
`default_nettype none
module esx_engine_model #(
    parameter int STOP_CYC = 20
) (
    input  wire logic       sys_clk,
    input  wire logic       runEn,
    input  wire logic       altOk,
    input  wire logic       stopSol,
    input  wire logic       startCmd,
    input  wire logic [3:0] pulseHalf,
    output logic            engineStopped,
    output logic [11:0]     excVolt,
    output logic            pickupIn,
    output logic            altFreqIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // runEn high: engine deaf to the solenoid
    logic running = 1'b0;
    int   stopCnt = 0;
    int   phase   = 0;
    always_ff @(posedge sys_clk) begin
        stopCnt <= stopSol ? stopCnt + 1 : 0;
        if (stopSol && !runEn && stopCnt >= STOP_CYC)
            running <= 1'b0;
        else if (startCmd && runEn)
            running <= 1'b1;
    end
    always_ff @(posedge sys_clk) begin
        phase <= (running && phase + 1 < 2 * pulseHalf) ? phase + 1 : 0;
    end
    // ==========
    // near 0 V and no pulses at standstill
    assign engineStopped = !running;
    assign excVolt       = (running && altOk) ? 12'h300 : 12'h000;
    assign pickupIn      = running && phase < pulseHalf;
    assign altFreqIn     = pickupIn;
endmodule // esx_engine_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the engine control block
// assumes the bound checker and the engine model beside the design
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    logic        sys_clk, srst, hsel, hwrite, hreadyout, hresp, startReq, stopReq, engineStopped;
    logic        supply24v, pickupIn, altFreqIn, startCmd, excCmd, excHighCurrent, runEn, altOk;
    logic        altFailAnomaly, engineStopFault;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] ecuRpm, engineRpm;
    logic [11:0] excVolt;
    logic [7:0]  speedPercent;
    logic [5:0]  staticOut;
    logic [3:0]  pulseHalf;
    logic [2:0]  hsize;
    logic [1:0]  htrans;
    int          mismatches = 0;
    int          cmp_count = 0;

    esx_engine_ctrl #(.EXC_HOLD_MS(30), .EXC_TOGGLE_MS(5), .EXC_AFTER_MS(5), .GATE_MS(10), .TICK_CYC(TK)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .startReq(startReq), .stopReq(stopReq), .engineStopped(engineStopped),
        .supply24v(supply24v), .excVolt(excVolt), .pickupIn(pickupIn), .altFreqIn(altFreqIn),
        .ecuRpm(ecuRpm), .staticOut(staticOut), .startCmd(startCmd), .excCmd(excCmd),
        .excHighCurrent(excHighCurrent), .altFailAnomaly(altFailAnomaly),
        .engineStopFault(engineStopFault), .engineRpm(engineRpm), .speedPercent(speedPercent));
    esx_engine_model u_eng (.sys_clk(sys_clk), .runEn(runEn), .altOk(altOk), .stopSol(|staticOut[5:1]),
        .startCmd(startCmd), .pulseHalf(pulseHalf), .engineStopped(engineStopped), .excVolt(excVolt),
        .pickupIn(pickupIn), .altFreqIn(altFreqIn));

    // ==========
    // reporting and comparison
    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmpRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: got %0h range %0h to %0h", $time, got, lo, hi);
        end
    endtask
    function automatic int expPct(input int rpm, input int rated);
        return (rpm * 100 / rated > 255) ? 255 : rpm * 100 / rated;
    endfunction
    // ==========
    // timing and bus
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic waitLvl(ref logic s, input logic v);
        for (int n = 0; s !== v; n++) begin
            if (n > 5000) begin
                mismatches++;
                test_done();
            end
            @(posedge sys_clk);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge sys_clk);
        waitLvl(hreadyout, 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge sys_clk);
        waitLvl(hreadyout, 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        cmpVal(rd, exp);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        ticks(100000);
        mismatches++;
        test_done();
    end
    // ==========
    // main sequence
    initial begin
        int          t, r, e;
        void'($urandom(32'h2DE3));
        {srst, hsel, hwrite, startReq, stopReq, supply24v, runEn, altOk} = 8'h81;
        {haddr, hwdata, htrans, hsize, ecuRpm} = '0;
        pulseHalf = 4'h2;
        ticks(5);
        srst <= 1'b0;
        supply24v <= $urandom_range(1, 0);
        ticks(1);
        chk(32'h00, 32'h0010_0200);
        chk(32'h04, 32'h2710);
        chk(32'h10, 32'h5DC);
        chk(32'h14, 32'h100);
        chk(32'h18, 32'h0);
        wr(32'h20, 32'hFFFF_FFFF);
        chk(32'h20, 32'h0);
        startReq <= 1'b1;
        ticks(3);
        cmpVal(startCmd, 32'h1);
        cmpVal(excCmd, 32'h0);
        cmpVal(excHighCurrent, !supply24v);
        startReq <= 1'b0;
        ticks(TK);
        wr(32'h00, 32'h0030_0201);
        startReq <= 1'b1;
        waitLvl(startCmd, 1'b1);
        cmpVal(excCmd, 32'h1);
        ticks(TK * 27);
        cmpVal(excCmd, 32'h1);
        for (int k = 0; k < 4; k++) begin
            ticks(TK * 5);
            cmpVal(excCmd, k[0]);
        end
        startReq <= 1'b0;
        ticks(TK * 3);
        cmpVal(excCmd, 32'h1);
        ticks(TK * 4);
        cmpVal(excCmd, 32'h0);
        runEn <= 1'b1;
        startReq <= 1'b1;
        waitLvl(engineStopped, 1'b0);
        ticks(TK * 190);
        cmpVal(startCmd, 32'h1);
        ticks(TK * 120);
        cmpVal(startCmd, 32'h0);
        startReq <= 1'b0;
        // about 25 pulses per gate window
        for (int i = 0; i < 4; i++) begin
            t = $urandom_range(60, 1);
            r = $urandom_range(3000, 1000);
            wr(32'h00, i == 3 ? 32'h0032_0201 : 32'h0030_0201);
            wr(32'h10, {8'h0, t[7:0], r[15:0]});
            ticks(TK * 30);
            cmpRange(engineRpm, 24 * 60 / t, 26 * 60 / t);
            cmpRange(speedPercent, expPct(24 * 60 / t, r), expPct(26 * 60 / t, r));
        end
        wr(32'h00, 32'h0030_0201);
        wr(32'h10, 32'h5DC);
        ticks(TK * 30);
        cmpVal(engineRpm, 32'h0);
        r = $urandom_range(32'h3FF, 32'h100);
        wr(32'h00, 32'h0031_0201);
        wr(32'h14, r);
        ticks(TK * 30);
        cmpRange(engineRpm, 24 * r / 256, 26 * r / 256);
        wr(32'h00, 32'h0033_0201);
        for (int i = 0; i < 3; i++) begin
            e = (i == 0) ? 32'hFFFF : $urandom_range(4000, 0);
            r = $urandom_range(3000, 1000);
            ecuRpm <= e[15:0];
            wr(32'h10, r);
            ticks(TK * 30);
            cmpVal(engineRpm, e);
            cmpVal(speedPercent, expPct(e, r));
        end
        for (int i = 0; i < 3; i++) begin
            wr(32'h08, i == 0 ? 32'h0200_0100 : i == 1 ? 32'h0100_0200 : 32'h0200_0000);
            bus(1'b0, 32'h18, 32'h0, rd);
            cmpVal(rd[0], i == 0);
        end
        wr(32'h08, 32'h0);
        wr(32'h04, 32'h3);
        stopReq <= 1'b1;
        ticks(TK);
        cmpVal(staticOut, 6'h04);
        stopReq <= 1'b0;
        ticks(TK * 3);
        cmpVal(staticOut, 6'h00);
        wr(32'h0C, 32'h5);
        altOk <= 1'b0;
        ticks(TK * 8);
        cmpVal(altFailAnomaly, 32'h1);
        for (int a = 0; a < 4; a++) begin
            wr(32'h00, 32'h0000_0201 | (a << 20));
            ticks(2);
            cmpVal(engineStopFault, a == 3);
        end
        wr(32'h0C, 32'h0);
        ticks(TK * 10);
        cmpVal(altFailAnomaly, 32'h0);
        altOk <= 1'b1;
        wr(32'h00, 32'h0030_0501);
        wr(32'h04, 32'h32);
        runEn <= 1'b0;
        stopReq <= 1'b1;
        ticks(3);
        cmpVal(staticOut, 6'h20);
        waitLvl(engineStopped, 1'b1);
        ticks(TK);
        cmpVal(staticOut, 6'h00);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
